// >>> logic/tpb_pkg.sv
package tpb_pkg;
    // Core clock rate and poll timing, times in microseconds
    localparam int unsigned CLK_MHZ = 10;
    localparam int unsigned POLL_GAP_US = 2500;
    localparam int unsigned POLL_GAP_CYC = POLL_GAP_US * CLK_MHZ;
    localparam int unsigned DLY1_US = 2500;
    localparam int unsigned DLY2_US = 5000;
    localparam int unsigned DLY3_US = 10000;
    localparam int unsigned DLY4_US = 50000;
    localparam int unsigned DLY5_US = 100000;
    localparam int unsigned DLY6_US = 500000;
    localparam logic [5:0][31:0] DLY_CYC_DEF = {32'(DLY6_US * CLK_MHZ), 32'(DLY5_US * CLK_MHZ),
        32'(DLY4_US * CLK_MHZ), 32'(DLY3_US * CLK_MHZ), 32'(DLY2_US * CLK_MHZ), 32'(DLY1_US * CLK_MHZ)};

    // Command codes
    localparam logic [7:0] CMD_TEMP_LAST = 8'h07;
    localparam logic [7:0] CMD_MAX_TEMP = 8'h08;
    localparam logic [7:0] CMD_FW_VER = 8'h09;
    localparam logic [7:0] CMD_MAX_SRC = 8'h0A;
    localparam logic [7:0] CMD_ALERT_SRC = 8'h0B;
    localparam logic [7:0] CMD_POLL_CTL = 8'h0C;
    localparam logic [7:0] CMD_BIT_RETRY = 8'h0D;
    localparam logic [7:0] CMD_OFFSET = 8'h0E;
    localparam logic [7:0] CMD_AVG_CTL = 8'h0F;
    localparam logic [7:0] CMD_LIMIT_FIRST = 8'h10;
    localparam logic [7:0] CMD_LIMIT_LAST = 8'h13;
    localparam logic [7:0] CMD_POLL_NOW = 8'h14;
    localparam logic [7:0] CMD_CLR_ALERT = 8'h15;

    // poll_feature_control fields
    localparam int EN_LSB = 8;
    localparam int TMO_BIT = 7;
    localparam int FMT_BIT = 6;
    localparam int PEC_BIT = 5;
    localparam int MASK_BIT = 4;
    localparam int RSV_BIT = 3;
    localparam int DLY_LSB = 0;
    localparam logic [2:0] DLY_NONE = 3'h0;
    localparam logic [2:0] DLY_RSV = 3'h7;
    // bit_time_retry_control fields
    localparam int BT_LSB = 8;
    localparam int RETRY_LSB = 0;
    localparam logic [7:0] BT_RSV = 8'h01;
    localparam logic [7:0] BT_MIN = 8'h02;

    // Reset values
    localparam logic [15:0] POLL_CTL_RST = 16'h00A5;
    localparam logic [15:0] BIT_RETRY_RST = 16'h0203;
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    localparam logic [7:0] AVG_CTL_RST = 8'h00;

    // Error words 8000h..81FFh share bits 15:9
    localparam logic [6:0] ERR_TOP = 7'h40;
    localparam int ALT_SHIFT = 6;
    // Arbitrary value
    localparam logic [15:0] FW_VERSION_DEF = 16'h0100;

    typedef enum logic [1:0] {
        TPB_RD_WORD = 2'h0,
        TPB_WR_WORD = 2'h1,
        TPB_SEND_BYTE = 2'h2
    } tpb_cmd_t;

    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_NEXT = 3'h1,
        M_WAIT = 3'h3,
        M_GAP = 3'h2,
        M_PAUSE = 3'h6
    } tpb_mst_t;

    typedef enum logic [1:0] {
        L_IDLE = 2'h0,
        L_ISSUE = 2'h1,
        L_WAIT = 2'h3
    } tpb_lst_t;
endpackage

// >>> logic/tpb_bridge_regs.sv
`timescale 1ns/1ps
// Overview of operation
// R1: Codes 00h-07h read latest temperature, socket 0 domain 0 up to socket 3 domain 1.
// R2: Code 08h reads highest temperature among enabled sockets and domains.
// R3: Code 09h reads a 16-bit firmware version word.
// R4: Code 0Ah reads which socket and domain gave the maximum.
// R5: Code 0Bh reads which socket and domain raised the pending alert.
// R6: Codes 0Ch-0Fh read and write the four configuration registers.
// R7: Codes 10h-13h hold per-socket alert limits; send-byte 15h clears alert.
// R8: Poll delay 0 means polling only on send-byte 14h.
// R9: Bits 15:8 enable each socket and domain for polling, reset 0.
// R10: Bit 7 enables bus lockup timeout, reset 1.
// R11: Bit 6 selects reduced format, reset 0.
// R12: Bit 5 enables packet error checksum, reset 1; bit 3 reserved zero.
// R13: Bit 4 masks temperature alerts, reset 0.
// R14: Bits 2:0 pick pause 2.5/5/10/50/100/500 ms; 7 reserved; reset 5.
// R15: At least 2.5 ms between successive reads within a round.
// R16: After a round, bus stays silent for the poll delay, then repeats.
// R17: Bits 15:8 of second register give originated bit time minus 1 us, reset 02h.
// R18: Bits 7:0 of second register limit retries of failed reads, reset 03h.
// R19: Offset register is added to every non-error result, reset 0000h.
// R20: Offset is degrees shifted left six; reduced format holds plain degrees.
// R21: Changing data format converts the stored offset to the new format.
// R22: Words 8000h-81FFh are error codes, passed without offset or conversion.
// R23: Reduced format shifts right six, filling with sign bit 15.
// R24: Unlisted codes read zero and ignore writes.
module tpb_bridge_regs #(
    parameter int unsigned GAP_CYC = tpb_pkg::POLL_GAP_CYC,
    parameter logic [5:0][31:0] DLY_CYC = tpb_pkg::DLY_CYC_DEF,
    parameter logic [15:0] FW_VERSION = tpb_pkg::FW_VERSION_DEF
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire tpb_pkg::tpb_cmd_t cmd_kind_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [15:0] cmd_wdata_in,
    output logic [15:0] rd_data_out,
    output logic rd_valid_out,
    output logic alert_pending_out,
    output logic pec_enable_out,
    output logic lockup_timeout_en_out,
    output logic alt_format_out,
    input wire logic peci_clk_in,
    output logic peci_req_out,
    output logic [1:0] peci_socket_out,
    output logic peci_domain_out,
    output logic [7:0] peci_bit_time_out,
    input wire logic peci_done_in,
    input wire logic peci_fail_in,
    input wire logic [15:0] peci_data_in
);
    import tpb_pkg::*;

    typedef struct packed {
        logic [15:0] poll_ctl;
        logic [15:0] bit_retry;
        logic [15:0] offset;
        logic [7:0] avg_ctl;
        logic [7:0][15:0] temp;
        logic [3:0][15:0] limit;
        logic alert_pend;
        logic [2:0] alert_src;
        tpb_mst_t st;
        logic [3:0] idx;
        logic [31:0] cnt;
        logic poll_req;
        logic req_tgl;
        logic [2:0] req_idx;
        logic [7:0] req_retry;
        logic [7:0] req_bt;
        logic [2:0] ack_sync;
        logic ack_filt;
        logic [15:0] rd_data;
        logic rd_valid;
    } tpb_main_t;

    typedef struct packed {
        logic [2:0] rst_sync;
        logic [2:0] req_sync;
        logic req_filt;
        tpb_lst_t st;
        logic [7:0] tries;
        logic [7:0] retry_lim;
        logic req;
        logic [2:0] idx;
        logic [7:0] bt;
        logic [15:0] data;
        logic ack_tgl;
    } tpb_link_t;

    localparam tpb_main_t M_RESET = '{poll_ctl: POLL_CTL_RST, bit_retry: BIT_RETRY_RST, offset: OFFSET_RST,
        avg_ctl: AVG_CTL_RST, st: M_IDLE, default: '0};
    localparam tpb_link_t L_RESET = '{st: L_IDLE, bt: BT_MIN, default: '0};

    tpb_main_t m_q;
    tpb_main_t m_d;
    tpb_link_t l_q;
    tpb_link_t l_d;

    function automatic logic is_err(input logic [15:0] v);
        return v[15:9] == ERR_TOP; // [R22]
    endfunction

    // Results are kept raw; offset and format are applied on the way out
    function automatic logic [15:0] present(input logic [15:0] raw, input logic [15:0] ctl,
                                            input logic [15:0] off);
        logic [15:0] off16;
        logic [15:0] sum;
        off16 = ctl[FMT_BIT] ? {off[15-ALT_SHIFT:0], {ALT_SHIFT{1'b0}}} : off; // [R20]
        sum = raw + off16; // [R19]
        if (is_err(raw)) begin
            return raw; // [R22]
        end
        if (ctl[FMT_BIT]) begin
            return {{ALT_SHIFT{sum[15]}}, sum[15:ALT_SHIFT]}; // [R11] [R23]
        end
        return sum;
    endfunction

    function automatic logic [31:0] delay_cycles(input logic [2:0] sel);
        logic [31:0] c;
        c = DLY_CYC[0];
        case (sel)
            3'h1: c = DLY_CYC[0];
            3'h2: c = DLY_CYC[1];
            3'h3: c = DLY_CYC[2];
            3'h4: c = DLY_CYC[3];
            3'h5: c = DLY_CYC[4];
            3'h6: c = DLY_CYC[5];
            default: c = DLY_CYC[0];
        endcase
        return c; // [R14]
    endfunction

    logic [15:0] max_val;
    logic [2:0] max_idx;
    logic [2:0] next_idx;
    logic next_found;
    logic ack_ev;
    logic [15:0] new_pres;
    logic [1:0] new_sock;
    logic [7:0] en;
    logic [2:0] dly;

    always_comb begin
        en = m_q.poll_ctl[EN_LSB +: 8]; // [R9]
        dly = m_q.poll_ctl[DLY_LSB +: 3];
        max_val = 16'h0000;
        max_idx = 3'h0;
        next_idx = 3'h0;
        next_found = 1'b0;
        // Error words never win; order of adjusted values matches raw order
        for (int i = 7; i >= 0; i--) begin
            if (en[i] && !is_err(m_q.temp[i]) && (!next_found || $signed(m_q.temp[i]) >= $signed(max_val))) begin
                max_val = m_q.temp[i]; // [R2]
                max_idx = 3'(i); // [R4]
                next_found = 1'b1;
            end
        end
        if (next_found) begin
            max_val = present(max_val, m_q.poll_ctl, m_q.offset);
        end
        next_found = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (en[i] && 4'(i) >= m_q.idx) begin
                next_idx = 3'(i);
                next_found = 1'b1;
            end
        end
        ack_ev = (m_q.ack_sync[2] == m_q.ack_sync[1]) && (m_q.ack_sync[2] != m_q.ack_filt);
        new_pres = present(l_q.data, m_q.poll_ctl, m_q.offset);
        new_sock = m_q.req_idx[2:1];
    end

    always_comb begin
        m_d = m_q;
        m_d.rd_valid = 1'b0;
        m_d.ack_sync = {m_q.ack_sync[1:0], l_q.ack_tgl};
        if (m_q.ack_sync[2] == m_q.ack_sync[1]) begin
            m_d.ack_filt = m_q.ack_sync[2];
        end

        if (cmd_valid_in) begin
            case (cmd_kind_in)
                TPB_RD_WORD: begin
                    m_d.rd_valid = 1'b1;
                    m_d.rd_data = 16'h0000; // [R24]
                    if (cmd_code_in <= CMD_TEMP_LAST) begin
                        m_d.rd_data = present(m_q.temp[cmd_code_in[2:0]], m_q.poll_ctl, m_q.offset); // [R1]
                    end else if (cmd_code_in == CMD_MAX_TEMP) begin
                        m_d.rd_data = max_val; // [R2]
                    end else if (cmd_code_in == CMD_FW_VER) begin
                        m_d.rd_data = FW_VERSION; // [R3]
                    end else if (cmd_code_in == CMD_MAX_SRC) begin
                        m_d.rd_data = {13'h0000, max_idx}; // [R4]
                    end else if (cmd_code_in == CMD_ALERT_SRC) begin
                        m_d.rd_data = {13'h0000, m_q.alert_src}; // [R5]
                    end else if (cmd_code_in == CMD_POLL_CTL) begin
                        m_d.rd_data = m_q.poll_ctl; // [R6]
                    end else if (cmd_code_in == CMD_BIT_RETRY) begin
                        m_d.rd_data = m_q.bit_retry; // [R6]
                    end else if (cmd_code_in == CMD_OFFSET) begin
                        m_d.rd_data = m_q.offset; // [R6]
                    end else if (cmd_code_in == CMD_AVG_CTL) begin
                        m_d.rd_data = {8'h00, m_q.avg_ctl}; // [R6]
                    end else if (cmd_code_in >= CMD_LIMIT_FIRST && cmd_code_in <= CMD_LIMIT_LAST) begin
                        m_d.rd_data = m_q.limit[cmd_code_in[1:0]]; // [R7]
                    end
                end
                TPB_WR_WORD: begin
                    if (cmd_code_in == CMD_POLL_CTL) begin
                        m_d.poll_ctl = cmd_wdata_in;
                        m_d.poll_ctl[RSV_BIT] = 1'b0; // [R12]
                        if (cmd_wdata_in[FMT_BIT] && !m_q.poll_ctl[FMT_BIT]) begin
                            m_d.offset = {{ALT_SHIFT{m_q.offset[15]}}, m_q.offset[15:ALT_SHIFT]}; // [R21]
                        end else if (!cmd_wdata_in[FMT_BIT] && m_q.poll_ctl[FMT_BIT]) begin
                            m_d.offset = {m_q.offset[15-ALT_SHIFT:0], {ALT_SHIFT{1'b0}}}; // [R21]
                        end
                    end else if (cmd_code_in == CMD_BIT_RETRY) begin
                        m_d.bit_retry = cmd_wdata_in; // [R6]
                        // Reserved bit time would be too short to drive
                        if (cmd_wdata_in[BT_LSB +: 8] == BT_RSV) begin
                            m_d.bit_retry[BT_LSB +: 8] = BT_MIN; // [R17]
                        end
                    end else if (cmd_code_in == CMD_OFFSET) begin
                        m_d.offset = cmd_wdata_in; // [R19]
                    end else if (cmd_code_in == CMD_AVG_CTL) begin
                        m_d.avg_ctl = cmd_wdata_in[7:0]; // [R6]
                    end else if (cmd_code_in >= CMD_LIMIT_FIRST && cmd_code_in <= CMD_LIMIT_LAST) begin
                        m_d.limit[cmd_code_in[1:0]] = cmd_wdata_in; // [R7]
                    end
                end
                TPB_SEND_BYTE: begin
                    if (cmd_code_in == CMD_POLL_NOW) begin
                        m_d.poll_req = 1'b1; // [R8]
                    end else if (cmd_code_in == CMD_CLR_ALERT) begin
                        m_d.alert_pend = 1'b0; // [R7]
                    end
                end
                default: begin
                    m_d.rd_valid = 1'b0; // [R24]
                end
            endcase
        end

        case (m_q.st)
            M_IDLE: begin
                // Delay 0 and the reserved 7 both leave polling to the host
                if (m_q.poll_req || (dly != DLY_NONE && dly != DLY_RSV)) begin // [R8]
                    m_d.poll_req = 1'b0;
                    m_d.idx = 4'h0;
                    m_d.st = M_NEXT;
                end
            end
            M_NEXT: begin
                if (next_found) begin
                    m_d.req_idx = next_idx; // [R9]
                    m_d.req_retry = m_q.bit_retry[RETRY_LSB +: 8]; // [R18]
                    m_d.req_bt = m_q.bit_retry[BT_LSB +: 8]; // [R17]
                    m_d.req_tgl = ~m_q.req_tgl;
                    m_d.st = M_WAIT;
                end else if (dly != DLY_NONE && dly != DLY_RSV) begin
                    m_d.cnt = delay_cycles(dly) - 32'h1; // [R16]
                    m_d.st = M_PAUSE;
                end else begin
                    m_d.st = M_IDLE; // [R8]
                end
            end
            M_WAIT: begin
                if (ack_ev) begin
                    m_d.temp[m_q.req_idx] = l_q.data; // [R1]
                    if (!m_q.poll_ctl[MASK_BIT] && !is_err(l_q.data) &&
                        $signed(new_pres) > $signed(m_q.limit[new_sock])) begin // [R13]
                        if (!m_q.alert_pend || (cmd_valid_in && cmd_kind_in == TPB_SEND_BYTE &&
                            cmd_code_in == CMD_CLR_ALERT)) begin
                            m_d.alert_src = m_q.req_idx; // [R5]
                        end
                        m_d.alert_pend = 1'b1; // [R7]
                    end
                    m_d.idx = {1'b0, m_q.req_idx} + 4'h1;
                    m_d.cnt = GAP_CYC - 32'h1; // [R15]
                    m_d.st = M_GAP;
                end
            end
            M_GAP: begin
                if (m_q.cnt == 32'h0) begin
                    m_d.st = M_NEXT; // [R15]
                end else begin
                    m_d.cnt = m_q.cnt - 32'h1;
                end
            end
            M_PAUSE: begin
                if (m_q.poll_req || m_q.cnt == 32'h0) begin
                    m_d.poll_req = 1'b0;
                    m_d.idx = 4'h0;
                    m_d.st = M_NEXT; // [R16]
                end else if (dly == DLY_NONE || dly == DLY_RSV) begin
                    m_d.st = M_IDLE; // [R8]
                end else begin
                    m_d.cnt = m_q.cnt - 32'h1; // [R16]
                end
            end
            default: begin
                m_d.st = M_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            m_q <= M_RESET; // [R9] [R10] [R11] [R12] [R13] [R14] [R17] [R18] [R19]
        end else begin
            m_q <= m_d;
        end
    end

    // Link side: request bundle stays stable while the toggle crosses
    always_comb begin
        l_d = l_q;
        l_d.rst_sync = {l_q.rst_sync[1:0], rst_in};
        l_d.req_sync = {l_q.req_sync[1:0], m_q.req_tgl};
        l_d.req = 1'b0;
        if (l_q.req_sync[2] == l_q.req_sync[1]) begin
            l_d.req_filt = l_q.req_sync[2];
        end
        case (l_q.st)
            L_IDLE: begin
                if (l_q.req_sync[2] == l_q.req_sync[1] && l_q.req_sync[2] != l_q.req_filt) begin
                    l_d.idx = m_q.req_idx;
                    l_d.bt = m_q.req_bt; // [R17]
                    l_d.retry_lim = m_q.req_retry;
                    l_d.tries = 8'h00;
                    l_d.st = L_ISSUE;
                end
            end
            L_ISSUE: begin
                l_d.req = 1'b1;
                l_d.st = L_WAIT;
            end
            L_WAIT: begin
                if (peci_done_in) begin
                    if (peci_fail_in && l_q.tries < l_q.retry_lim) begin
                        l_d.tries = l_q.tries + 8'h01; // [R18]
                        l_d.st = L_ISSUE;
                    end else begin
                        l_d.data = peci_data_in;
                        l_d.ack_tgl = ~l_q.ack_tgl;
                        l_d.st = L_IDLE;
                    end
                end
            end
            default: begin
                l_d.st = L_IDLE;
            end
        endcase
        if (l_q.rst_sync[2]) begin
            l_d = L_RESET;
            l_d.rst_sync = {l_q.rst_sync[1:0], rst_in};
            l_d.req_sync = {l_q.req_sync[1:0], m_q.req_tgl};
        end
    end

    always_ff @(posedge peci_clk_in) begin
        l_q <= l_d;
    end

    assign rd_data_out = m_q.rd_data;
    assign rd_valid_out = m_q.rd_valid;
    assign alert_pending_out = m_q.alert_pend;
    assign pec_enable_out = m_q.poll_ctl[PEC_BIT]; // [R12]
    assign lockup_timeout_en_out = m_q.poll_ctl[TMO_BIT]; // [R10]
    assign alt_format_out = m_q.poll_ctl[FMT_BIT]; // [R11]
    assign peci_req_out = l_q.req;
    assign peci_socket_out = l_q.idx[2:1];
    assign peci_domain_out = l_q.idx[0];
    assign peci_bit_time_out = l_q.bt; // [R17]
endmodule

// >>> test/tpb_bridge_regs_assertions.sv
`timescale 1ns/1ps
module tpb_bridge_regs_assertions
    import tpb_pkg::*;
#(
    parameter int unsigned GAP_CYC = POLL_GAP_CYC,
    parameter logic [15:0] FW_VERSION = FW_VERSION_DEF
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire tpb_pkg::tpb_cmd_t cmd_kind_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [15:0] cmd_wdata_in,
    input wire logic [15:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic alert_pending_out,
    input wire logic pec_enable_out,
    input wire logic lockup_timeout_en_out,
    input wire logic alt_format_out,
    input wire logic peci_clk_in,
    input wire logic peci_req_out,
    input wire logic [7:0] peci_bit_time_out,
    input wire logic peci_done_in,
    input wire logic peci_fail_in
);
    localparam int QUIET_MIN = GAP_CYC * 10 / 3 - 6;
    wire logic rd_cmd = cmd_valid_in && cmd_kind_in == TPB_RD_WORD;
    wire logic cfg_wr = cmd_valid_in && cmd_kind_in == TPB_WR_WORD && cmd_code_in == CMD_POLL_CTL;
    logic [31:0] quiet_q;
    always_ff @(posedge peci_clk_in) begin
        if (rst_in) begin
            quiet_q <= '1;
        end else if (peci_done_in && !peci_fail_in) begin
            quiet_q <= '0;
        end else if (quiet_q != '1) begin
            quiet_q <= quiet_q + 32'h1;
        end
    end
    property p_cfg;
        logic [15:0] v;
        @(posedge mclk_in) disable iff (rst_in)
        (cfg_wr, v = cmd_wdata_in) |=> {lockup_timeout_en_out, alt_format_out, pec_enable_out} == v[TMO_BIT -: 3];
    endproperty
    AST_READ_ANSWER: assert property (@(posedge mclk_in) disable iff (rst_in) rd_cmd |=> rd_valid_out)
        else $error("no read answer");
    AST_NO_SPURIOUS_VALID: assert property (@(posedge mclk_in) disable iff (rst_in)
        rd_valid_out |-> $past(rd_cmd)) else $error("stray read valid");
    AST_UNLISTED_ZERO: assert property (@(posedge mclk_in) disable iff (rst_in)
        rd_cmd && cmd_code_in > CMD_CLR_ALERT |=> rd_data_out == 16'h0000) else $error("unlisted not zero");
    AST_FW_WORD: assert property (@(posedge mclk_in) disable iff (rst_in)
        rd_cmd && cmd_code_in == CMD_FW_VER |=> rd_data_out == FW_VERSION) else $error("bad version");
    AST_RSV_BIT_ZERO: assert property (@(posedge mclk_in) disable iff (rst_in)
        rd_cmd && cmd_code_in == CMD_POLL_CTL |=> !rd_data_out[RSV_BIT]) else $error("reserved bit set");
    AST_CFG_OUTPUTS: assert property (p_cfg)
        else $error("outputs miss write");
    AST_BITTIME_VALID: assert property (@(posedge peci_clk_in) disable iff (rst_in)
        peci_req_out |-> peci_bit_time_out >= BT_MIN) else $error("bit time too low");
    AST_REQ_GAP: assert property (@(posedge peci_clk_in) disable iff (rst_in)
        peci_req_out |-> quiet_q >= QUIET_MIN) else $error("reads too close");
    C_READ: cover property (@(posedge mclk_in) disable iff (rst_in) rd_cmd ##1 rd_valid_out);
    C_RETRY: cover property (@(posedge peci_clk_in) disable iff (rst_in) peci_done_in && peci_fail_in ##2 peci_req_out);
    C_ALERT: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(alert_pending_out));
endmodule

// >>> test/tpb_peci_engine.sv
`timescale 1ns/1ps
module tpb_peci_engine (
    input wire logic peci_clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic [2:0] idx_in,
    input wire logic [7:0][15:0] temps_in,
    input wire logic [1:0] fails_in,
    input wire logic slow_in,
    output logic done_out,
    output logic fail_out,
    output logic [15:0] data_out
);
    logic busy;
    int wait_cnt;
    int tries;
    always @(posedge peci_clk_in) begin
        done_out <= 1'b0;
        fail_out <= 1'b0;
        data_out <= ~data_out;
        if (rst_in) begin
            busy <= 1'b0;
            tries <= 0;
            data_out <= 16'h5A5A;
        end else if (req_in && !busy) begin
            busy <= 1'b1;
            wait_cnt <= slow_in ? 40 : 2;
        end else if (busy && wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end else if (busy) begin
            busy <= 1'b0;
            done_out <= 1'b1;
            fail_out <= tries < fails_in;
            tries <= tries < fails_in ? tries + 1 : 0;
            data_out <= tries < fails_in ? 16'h8001 : temps_in[idx_in];
        end
    end
endmodule

// >>> test/tpb_bridge_regs_tb_top.sv
`timescale 1ns/1ps
module tpb_bridge_regs_tb_top;
    import tpb_pkg::*;
    logic mclk_in = 0, peci_clk_in = 0, rst_in = 1, cmd_valid_in = 0, slow = 0;
    tpb_cmd_t cmd_kind_in = TPB_RD_WORD;
    logic [7:0] cmd_code_in = 8'h00;
    logic [15:0] cmd_wdata_in = 16'h0000;
    logic [15:0] rd_data_out, pdata;
    logic rd_valid_out, alert, pec, tmo, alt, req, dom, done, fail;
    logic [1:0] sock, fails = 2'h0;
    logic [7:0] bt;
    logic [7:0][15:0] temps = {32'h0, 16'h0140, 32'h0, 16'hFF80, 32'h0};
    logic [15:0] rv [20] = '{9: 16'h0100, 12: 16'h00A5, 13: 16'h0203, default: 0};
    int err_count = 0, samples_checked = 0, req_count = 0, d;
    tpb_bridge_regs #(.GAP_CYC(20), .DLY_CYC({32'h78, 32'h64, 32'h50, 32'h3C, 32'h28, 32'h14})) u_dut (
        .mclk_in(mclk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_kind_in(cmd_kind_in),
        .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out), .alert_pending_out(alert), .pec_enable_out(pec),
        .lockup_timeout_en_out(tmo), .alt_format_out(alt), .peci_clk_in(peci_clk_in), .peci_req_out(req),
        .peci_socket_out(sock), .peci_domain_out(dom), .peci_bit_time_out(bt), .peci_done_in(done),
        .peci_fail_in(fail), .peci_data_in(pdata));
    tpb_peci_engine u_peci (.peci_clk_in(peci_clk_in), .rst_in(rst_in), .req_in(req), .idx_in({sock, dom}),
        .temps_in(temps), .fails_in(fails), .slow_in(slow), .done_out(done), .fail_out(fail), .data_out(pdata));
    initial forever #50 mclk_in = ~mclk_in;
    initial #7 forever #15 peci_clk_in = ~peci_clk_in;
    always @(posedge peci_clk_in) if (req) req_count <= req_count + 1;
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input tpb_cmd_t k, input logic [7:0] c, input logic [15:0] w);
        @(negedge mclk_in);
        cmd_valid_in = 1;
        cmd_kind_in = k;
        cmd_code_in = c;
        cmd_wdata_in = w;
        @(negedge mclk_in);
        cmd_valid_in = 0;
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        cmd(TPB_RD_WORD, c, 16'h0000);
        check({15'h0, rd_valid_out}, 16'h0001);
        check(rd_data_out, exp);
    endtask
    task automatic poll(input int n);
        int base = req_count;
        cmd(TPB_SEND_BYTE, CMD_POLL_NOW, 16'h0000);
        for (int i = 0; i < 3000 && req_count < base + n; i++) @(negedge mclk_in);
        repeat (150) @(negedge mclk_in);
        check(16'(req_count - base), 16'(n));
    endtask
    initial begin
        repeat (20000) @(posedge mclk_in);
        err_count++;
        conclude();
    end
    initial begin
        repeat (3) @(negedge mclk_in);
        rst_in = 0;
        foreach (rv[i]) rd(8'(i), rv[i]);
        rd(8'h16, 16'h0000);
        check({13'h0, pec, tmo, alt}, 16'h0006);
        for (int i = 16; i < 20; i++) cmd(TPB_WR_WORD, 8'(i), 16'h7FFF);
        rd(CMD_LIMIT_LAST, 16'h7FFF);
        cmd(TPB_WR_WORD, CMD_FW_VER, 16'hFFFF);
        cmd(TPB_WR_WORD, 8'h16, 16'hFFFF);
        rd(CMD_FW_VER, 16'h0100);
        rd(8'h16, 16'h0000);
        cmd(TPB_WR_WORD, CMD_BIT_RETRY, 16'h0105);
        rd(CMD_BIT_RETRY, 16'h0205);
        cmd(TPB_WR_WORD, CMD_BIT_RETRY, 16'h0303);
        cmd(TPB_WR_WORD, CMD_POLL_CTL, 16'h2428);
        rd(CMD_POLL_CTL, 16'h2420);
        check({13'h0, pec, tmo, alt}, 16'h0004);
        repeat (300) @(negedge mclk_in);
        check(16'(req_count), 16'h0000);
        poll(2);
        rd(8'h02, 16'hFF80);
        rd(8'h05, 16'h0140);
        rd(8'h00, 16'h0000);
        rd(CMD_MAX_TEMP, 16'h0140);
        rd(CMD_MAX_SRC, 16'h0005);
        d = req_count;
        cmd(TPB_WR_WORD, CMD_POLL_CTL, 16'h2421);
        repeat (300) @(negedge mclk_in);
        d = req_count - d;
        check({15'h0, d >= 4 && d <= 15}, 16'h0001);
        cmd(TPB_WR_WORD, CMD_POLL_CTL, 16'h2420);
        repeat (200) @(negedge mclk_in);
        cmd(TPB_WR_WORD, CMD_OFFSET, 16'h17C0);
        rd(8'h02, 16'h1740);
        cmd(TPB_WR_WORD, CMD_POLL_CTL, 16'h2460);
        check({15'h0, alt}, 16'h0001);
        rd(CMD_OFFSET, 16'h005F);
        rd(8'h02, 16'h005D);
        rd(8'h05, 16'h0064);
        fails = 2'h1;
        cmd(TPB_WR_WORD, CMD_BIT_RETRY, 16'h0300);
        poll(2);
        rd(8'h02, 16'h8001);
        fails = 2'h2;
        slow = 1;
        cmd(TPB_WR_WORD, CMD_BIT_RETRY, 16'h0303);
        poll(6);
        rd(8'h02, 16'h005D);
        check({8'h0, bt}, 16'h0003);
        fails = 2'h0;
        cmd(TPB_WR_WORD, CMD_POLL_CTL, 16'h2470);
        cmd(TPB_WR_WORD, 8'h12, 16'h0060);
        poll(2);
        check({15'h0, alert}, 16'h0000);
        cmd(TPB_WR_WORD, CMD_POLL_CTL, 16'h2460);
        poll(2);
        check({15'h0, alert}, 16'h0001);
        rd(CMD_ALERT_SRC, 16'h0005);
        cmd(TPB_WR_WORD, 8'h12, 16'h7FFF);
        cmd(TPB_SEND_BYTE, CMD_CLR_ALERT, 16'h0000);
        check({15'h0, alert}, 16'h0000);
        conclude();
    end
endmodule
bind tpb_bridge_regs tpb_bridge_regs_assertions #(.GAP_CYC(GAP_CYC), .FW_VERSION(FW_VERSION)) u_chk (
    .mclk_in(mclk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_kind_in(cmd_kind_in),
    .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .alert_pending_out(alert_pending_out), .pec_enable_out(pec_enable_out),
    .lockup_timeout_en_out(lockup_timeout_en_out), .alt_format_out(alt_format_out),
    .peci_clk_in(peci_clk_in), .peci_req_out(peci_req_out), .peci_bit_time_out(peci_bit_time_out),
    .peci_done_in(peci_done_in), .peci_fail_in(peci_fail_in));
